/* File: bench/hwm_monitor_asserts.sv */
module hwm_monitor_asserts #(
    parameter int IDLE_CLKS = 45000
) (
    input wire logic sys_clk_in,
    input wire logic reset_in,
    input wire logic conv_clk_in,
    input wire logic smb_scl_in,
    input wire logic smb_sda_in,
    input wire logic smb_sda_out,
    input wire logic smb_sda_oe_out,
    input wire logic fan_drive_pin_two_out,
    input wire logic fan_drive_pin_two_oe_out,
    input wire logic tach_input_pin_three_out,
    input wire logic tach_input_pin_three_oe_out,
    input wire logic [2:0] adc_sel_out,
    input wire logic adc_busy_out,
    input wire hwm_pkg::hwm_byte_t adc_data_in,
    input wire logic adc_fault_in
);
    timeunit 1ns;
    timeprecision 100ps;
    import hwm_pkg::*;
    logic [7:0] busy_run_q;
    // Saturates, so a whole pass with busy held high still counts as long enough
    always_ff @(posedge conv_clk_in) begin
        if (reset_in || !adc_busy_out) busy_run_q <= 8'h00;
        else if (busy_run_q != 8'hFF) busy_run_q <= busy_run_q + 8'h01;
    end
    sequence s_scl_high2;
        smb_scl_in ##1 smb_scl_in;
    endsequence
    sequence s_reset_held;
        reset_in [*5];
    endsequence
    a_sda_drive_low: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        smb_sda_out == 1'b0) else $error("data pin driven high");
    a_alert_pins_low: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        fan_drive_pin_two_out == 1'b0 && tach_input_pin_three_out == 1'b0) else $error("alert pin driven high");
    a_sda_steady_scl: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        s_scl_high2 |-> $stable(smb_sda_oe_out)) else $error("data line moved while clock high");
    a_oe_reset_off: assert property (@(posedge sys_clk_in)
        reset_in |=> !smb_sda_oe_out && !fan_drive_pin_two_oe_out && !tach_input_pin_three_oe_out)
        else $error("pin enable active in reset");
    a_sel_in_range: assert property (@(posedge conv_clk_in) disable iff (reset_in)
        adc_sel_out <= 3'h4) else $error("input select out of range");
    a_sel_order: assert property (@(posedge conv_clk_in) disable iff (reset_in)
        $changed(adc_sel_out) |-> adc_sel_out == $past(adc_sel_out) + 3'h1 || adc_sel_out == 3'h0)
        else $error("input order broken");
    a_conv_min_len: assert property (@(posedge conv_clk_in) disable iff (reset_in)
        $fell(adc_busy_out) |-> busy_run_q >= 8'd68) else $error("conversion too short");
    a_conv_reset_idle: assert property (@(posedge conv_clk_in)
        s_reset_held |-> !adc_busy_out && adc_sel_out == 3'h0) else $error("sequencer active in reset");
endmodule
bind hwm_monitor hwm_monitor_asserts #(.IDLE_CLKS(IDLE_CLKS)) u_hwm_chk (
    .sys_clk_in(sys_clk_in), .reset_in(reset_in), .conv_clk_in(conv_clk_in), .smb_scl_in(smb_scl_in),
    .smb_sda_in(smb_sda_in), .smb_sda_out(smb_sda_out), .smb_sda_oe_out(smb_sda_oe_out),
    .fan_drive_pin_two_out(fan_drive_pin_two_out), .fan_drive_pin_two_oe_out(fan_drive_pin_two_oe_out),
    .tach_input_pin_three_out(tach_input_pin_three_out),
    .tach_input_pin_three_oe_out(tach_input_pin_three_oe_out), .adc_sel_out(adc_sel_out),
    .adc_busy_out(adc_busy_out), .adc_data_in(adc_data_in), .adc_fault_in(adc_fault_in));

/* File: bench/hwm_monitor_tb_top.sv */
`include "hwm_consts.svh"
module hwm_monitor_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import hwm_pkg::*;
    logic sys_clk, conv_clk, rst, fault, scl, sda_low, sda_oe, fan_oe, tach_oe, busy, ok;
    logic [2:0] sel;
    logic [7:0] r, d;
    hwm_byte_t adc_data;
    wire logic sda_wire = !(sda_low || sda_oe); // Pulled up when nobody pulls low
    int bad_count = 0;
    int n_compared = 0;
    logic [31:0] lfsr = 32'h40FF;
    hwm_monitor #(.IDLE_CLKS(200)) dut (
        .sys_clk_in(sys_clk), .reset_in(rst), .conv_clk_in(conv_clk), .smb_scl_in(scl), .smb_sda_in(sda_wire),
        .smb_sda_out(), .smb_sda_oe_out(sda_oe), .fan_drive_pin_two_out(), .fan_drive_pin_two_oe_out(fan_oe),
        .tach_input_pin_three_out(), .tach_input_pin_three_oe_out(tach_oe), .adc_sel_out(sel),
        .adc_busy_out(busy), .adc_data_in(adc_data), .adc_fault_in(fault));
    hwm_smb_host host (.sys_clk_in(sys_clk), .sda_in(sda_wire), .scl_out(scl), .sda_low_out(sda_low));
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = !sys_clk;
    end
    initial begin
        conv_clk = 1'b0;
        #7.3;
        forever #16 conv_clk = !conv_clk;
    end
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Equal to the high limit already counts as a violation
    function automatic logic [7:0] d1_status(input logic [7:0] rv, input logic [7:0] hi);
        return {7'h00, rv >= hi};
    endfunction
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic w(input logic [7:0] ra, input logic [7:0] v);
        host.wr(ra, v, ok);
        check({7'h00, ok}, 8'h01);
    endtask
    task automatic rc(input logic [7:0] ra, input logic [7:0] exp);
        host.rd(ra, d);
        check(d, exp);
    endtask
    task automatic wait_alert();
        for (int i = 0; i < 30000 && fan_oe !== 1'b1; i++) begin
            @(posedge sys_clk);
            #1;
        end
    endtask
    task automatic print_verdict();
        if (bad_count == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        rst = 1'b1;
        fault = 1'b0; // Fault path not exercised, length limit
        lfsr = lfsr_next(lfsr);
        r = 8'h10 + {1'b0, lfsr[6:0]};
        adc_data = r;
        repeat (6) @(posedge conv_clk);
        @(posedge sys_clk);
        #1 rst = 1'b0;
        repeat (4) @(posedge sys_clk);
        rc(`HWM_REG_SFR, 8'h40);
        rc(`HWM_REG_VOLT_EN, 8'h06);
        rc(`HWM_REG_TEMP_EN, 8'h0E);
        rc(8'h83, 8'h00);
        host.ara(ok, d);
        check({7'h00, ok}, 8'h00);
        w(`HWM_REG_LIMIT_BASE + 8'h01, r);
        w(`HWM_REG_TEMP_EN, 8'h0F);
        w(`HWM_REG_CFG, 8'h02);
        w(`HWM_REG_SFR, 8'h24);
        w(`HWM_REG_START, 8'h01);
        wait_alert();
        check({7'h00, fan_oe}, 8'h01);
        check({7'h00, tach_oe}, 8'h00);
        rc(`HWM_REG_READ_BASE, r);
        rc(`HWM_REG_STAT1, d1_status(r, r));
        rc(`HWM_REG_STAT2, 8'h00);
        host.ara(ok, d);
        check({7'h00, ok}, 8'h01);
        check(d, {`HWM_SLAVE_ADDR, 1'b1});
        check({7'h00, fan_oe}, 8'h00);
        rc(`HWM_REG_SFR, 8'h20);
        w(`HWM_REG_CFG, 8'h00);
        w(`HWM_REG_SFR, 8'h26);
        host.ara(ok, d);
        check({7'h00, ok}, 8'h01);
        w(`HWM_REG_CFG, 8'h03);
        w(`HWM_REG_SFR, 8'h26);
        check({7'h00, fan_oe}, 8'h00);
        wait_alert();
        check({7'h00, fan_oe}, 8'h01);
        check({7'h00, tach_oe}, 8'h01);
        w(`HWM_REG_START, 8'h00);
        rc(`HWM_REG_STAT1, 8'h01);
        w(`HWM_REG_LIMIT_BASE + 8'h01, 8'hFF);
        rc(`HWM_REG_STAT1, 8'h01);
        rc(`HWM_REG_STAT1, 8'h00);
        w(`HWM_REG_CFG, 8'h80);
        rc(`HWM_REG_CFG, 8'h00);
        rc(`HWM_REG_SFR, 8'h40);
        rc(`HWM_REG_READ_BASE, r);
        for (int c = 0; c < 8; c++) begin
            w(`HWM_REG_SFR, {c[2:0], 5'h00});
            rc(`HWM_REG_SFR, {c[2:0], 5'h00});
        end
        print_verdict();
    end
    initial begin
        repeat (95000) @(posedge sys_clk);
        bad_count++;
        print_verdict();
    end
endmodule

/* File: bench/hwm_smb_host.sv */
`include "hwm_consts.svh"
module hwm_smb_host (
    input wire logic sys_clk_in,
    input wire logic sda_in,
    output logic scl_out,
    output logic sda_low_out
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam int HALF = 8; // Device syncs the pins, needs 8 cycles per level
    initial begin
        scl_out = 1'b1;
        sda_low_out = 1'b0;
    end
    task automatic hold();
        repeat (HALF) @(posedge sys_clk_in);
        #1;
    endtask
    task automatic bit_io(input logic b, output logic r);
        sda_low_out = !b;
        hold();
        scl_out = 1'b1;
        hold();
        r = sda_in;
        scl_out = 1'b0;
    endtask
    // Released ack slot doubles as the host NACK after a read byte
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
        logic t;
        for (int i = 7; i >= 0; i--) begin
            bit_io(tx[i], t);
            rx[i] = t;
        end
        bit_io(1'b1, t);
        ack = !t;
    endtask
    task automatic start();
        sda_low_out = 1'b0;
        hold();
        scl_out = 1'b1;
        hold();
        sda_low_out = 1'b1;
        hold();
        scl_out = 1'b0;
    endtask
    task automatic stop();
        sda_low_out = 1'b1;
        hold();
        scl_out = 1'b1;
        hold();
        sda_low_out = 1'b0;
        hold();
    endtask
    task automatic wr(input logic [7:0] ra, input logic [7:0] val, output logic ok);
        logic [7:0] rx;
        logic a0, a1, a2;
        start();
        xfer({`HWM_SLAVE_ADDR, 1'b0}, rx, a0);
        xfer(ra, rx, a1);
        xfer(val, rx, a2);
        stop();
        ok = a0 & a1 & a2;
    endtask
    task automatic rd(input logic [7:0] ra, output logic [7:0] val);
        logic a;
        start();
        xfer({`HWM_SLAVE_ADDR, 1'b0}, val, a);
        xfer(ra, val, a);
        start();
        xfer({`HWM_SLAVE_ADDR, 1'b1}, val, a);
        xfer(8'hFF, val, a);
        stop();
    endtask
    // Alert query, then NACK and STOP; software re-enables afterwards
    task automatic ara(output logic ok, output logic [7:0] val);
        logic n;
        start();
        xfer({`HWM_ARA_ADDR, 1'b1}, val, ok);
        val = 8'h00;
        if (ok) begin
            xfer(8'hFF, val, n);
        end
        stop();
    endtask
endmodule

/* File: rtl/hwm_consts.svh */
`ifndef HWM_CONSTS_SVH
`define HWM_CONSTS_SVH
// What this block does
// - Answer alert query only when enabled and pending
// - Pull alert line low for enabled status
// - Alert answer carries own address, top bits
// - Alert frame: address, read, ack, byte, nack
// - Clear global enable after acknowledging alert query
// - Reassert alert next pass once re-enabled
// - Alert query answered regardless of pin setup
// - Start bit begins monitoring
// - Store readings, compare limits, record faults
// - Power-up defaults all but reading registers
// - Soft reset bit, self clearing
// - Mode bit chooses continuous or cycle
// - Temperature 96 clocks, voltage 68 clocks
// - Averaging code decoded, highest bit wins
// - Reading updated after all averaged samples
// - Averaging field resets to 010
// - Fixed input order each pass
// - Continuous mode restarts pass immediately
// - Cycle mode idles one second between passes
// - Limit reached or passed sets status
// - Readings readable anytime, one update per pass
// - Status read clears only inactive conditions

`define HWM_REG_START 8'h40
`define HWM_REG_STAT1 8'h41
`define HWM_REG_STAT2 8'h42
`define HWM_REG_SFR 8'h7C
`define HWM_REG_VOLT_EN 8'h7E
`define HWM_REG_CFG 8'h7F
`define HWM_REG_TEMP_EN 8'h82
`define HWM_REG_READ_BASE 8'h25
`define HWM_REG_LIMIT_BASE 8'h44

`define HWM_SLAVE_ADDR 7'h2E
`define HWM_ARA_ADDR 7'h0C

`define HWM_SFR_RESET 8'h40
`define HWM_TEMP_EN_RESET 8'h0E
`define HWM_VOLT_EN_RESET 8'h06
`define HWM_LIMIT_LO_RESET 8'h00
`define HWM_LIMIT_HI_RESET 8'hFF
`define HWM_FAULT_READING 8'h80

`define HWM_SFR_IRQ_EN 2
`define HWM_SFR_MODE 1
`define HWM_CFG_SOFT 7
`define HWM_CFG_PIN2 1
`define HWM_CFG_PIN3 0

`define HWM_TEMP_CLKS 7'd96
`define HWM_VOLT_CLKS 7'd68
`define HWM_CONV_CLK_HZ 45000
`define HWM_IDLE_TIME_MS 1000
`define HWM_IDLE_CLKS (`HWM_IDLE_TIME_MS * `HWM_CONV_CLK_HZ / 1000)
`define HWM_NUM_INPUTS 5
`define HWM_LAST_INPUT 3'd4
`endif

/* File: rtl/hwm_monitor.sv */
`include "hwm_consts.svh"
module hwm_monitor #(
    parameter int IDLE_CLKS = `HWM_IDLE_CLKS
) (
    input wire logic sys_clk_in,
    input wire logic reset_in,
    input wire logic conv_clk_in,
    input wire logic smb_scl_in,
    input wire logic smb_sda_in,
    output logic smb_sda_out,
    output logic smb_sda_oe_out,
    output logic fan_drive_pin_two_out,
    output logic fan_drive_pin_two_oe_out,
    output logic tach_input_pin_three_out,
    output logic tach_input_pin_three_oe_out,
    output logic [2:0] adc_sel_out,
    output logic adc_busy_out,
    input wire hwm_pkg::hwm_byte_t adc_data_in,
    input wire logic adc_fault_in
);
    import hwm_pkg::*;

    // Pin synchronisers; stage 0 feeds only stage 1
    logic [2:0] scl_sync_q;
    logic [2:0] sda_sync_q;
    wire scl_now = scl_sync_q[1];
    wire scl_prev = scl_sync_q[2];
    wire sda_now = sda_sync_q[1];
    wire sda_prev = sda_sync_q[2];
    wire scl_rise = scl_now & ~scl_prev;
    wire scl_fall = ~scl_now & scl_prev;
    wire smb_start = scl_now & scl_prev & sda_prev & ~sda_now;
    wire smb_stop = scl_now & scl_prev & ~sda_prev & sda_now;

    hwm_smb_state_t smb_state_q, smb_state_d;
    logic [3:0] bit_cnt_q, bit_cnt_d;
    hwm_byte_t shift_q, shift_d;
    hwm_byte_t tx_q, tx_d;
    hwm_byte_t ptr_q, ptr_d;
    logic ara_pend_q, ara_pend_d;
    logic wr_strobe;
    logic rd_strobe;
    logic ara_ack;

    // Register state
    logic start_q;
    hwm_byte_t sfr_q;
    logic [1:0] cfg_q;
    hwm_byte_t volt_en_q;
    hwm_byte_t temp_en_q;
    hwm_byte_t lim_lo_q [`HWM_NUM_INPUTS];
    hwm_byte_t lim_hi_q [`HWM_NUM_INPUTS];
    hwm_byte_t reading_q [`HWM_NUM_INPUTS];
    logic [4:0] stat1_q;
    logic [1:0] stat2_q;
    logic [1:0] fault_now_q;
    logic armed_q;
    logic pin2_oe_q;
    logic pin3_oe_q;

    // Result crossing from the conversion domain
    logic [2:0] res_sync_q;
    logic res_tgl_q;
    hwm_byte_t res_val_q;
    logic [2:0] res_idx_q;
    logic res_fault_q;
    wire res_new = res_sync_q[1] ^ res_sync_q[2];
    wire pass_done = res_new && (res_idx_q == `HWM_LAST_INPUT);

    wire [6:0] own_addr = `HWM_SLAVE_ADDR;
    wire addr_own = (shift_q[7:1] == own_addr);
    wire addr_ara = (shift_q[7:1] == `HWM_ARA_ADDR);
    wire addr_rd = shift_q[0];

    wire soft_rst = wr_strobe && (ptr_q == `HWM_REG_CFG) && shift_q[`HWM_CFG_SOFT];
    wire reg_rst = reset_in | soft_rst;
    wire wr_start = wr_strobe && (ptr_q == `HWM_REG_START);
    wire wr_sfr = wr_strobe && (ptr_q == `HWM_REG_SFR);
    wire wr_cfg = wr_strobe && (ptr_q == `HWM_REG_CFG);
    wire wr_volt = wr_strobe && (ptr_q == `HWM_REG_VOLT_EN);
    wire wr_temp = wr_strobe && (ptr_q == `HWM_REG_TEMP_EN);
    wire clr_stat1 = rd_strobe && (ptr_q == `HWM_REG_STAT1);
    wire clr_stat2 = rd_strobe && (ptr_q == `HWM_REG_STAT2);

    wire [4:0] ind_en = {temp_en_q[3], volt_en_q[2], volt_en_q[1], temp_en_q[2], temp_en_q[1]};
    wire temp_hit = temp_en_q[0] & (stat1_q[0] | stat1_q[1] | stat1_q[4]);
    wire volt_hit = volt_en_q[0] & (stat1_q[2] | stat1_q[3]);
    wire ara_ok = sfr_q[`HWM_SFR_IRQ_EN] & (temp_hit | volt_hit);
    wire alert = ara_ok & armed_q & start_q;

    logic [4:0] cond_now;
    logic [4:0] set1;
    logic [4:0] stat1_d;
    genvar gi;
    generate
        for (gi = 0; gi < `HWM_NUM_INPUTS; gi++) begin : g_cmp
            // Equal to a limit counts as a violation
            assign cond_now[gi] = (reading_q[gi] <= lim_lo_q[gi]) || (reading_q[gi] >= lim_hi_q[gi]);
            assign set1[gi] = res_new && (res_idx_q == 3'(gi)) && ind_en[gi] &&
                ((res_val_q <= lim_lo_q[gi]) || (res_val_q >= lim_hi_q[gi]));
            // Set beats the clear-on-read
            assign stat1_d[gi] = set1[gi] | (stat1_q[gi] & ~(clr_stat1 & ~cond_now[gi]));
        end
    endgenerate

    wire [1:0] set2 = {res_new && res_fault_q && (res_idx_q == `HWM_LAST_INPUT) && ind_en[4],
                       res_new && res_fault_q && (res_idx_q == 3'd0) && ind_en[0]};
    wire [1:0] stat2_d = set2 | (stat2_q & ~({2{clr_stat2}} & ~fault_now_q));

    function automatic hwm_byte_t read_mux(input hwm_byte_t a);
        hwm_byte_t v;
        v = 8'h00;
        for (int i = 0; i < `HWM_NUM_INPUTS; i++) begin
            if (a == 8'(`HWM_REG_READ_BASE + i)) begin
                v = reading_q[i];
            end
            if (a == 8'(`HWM_REG_LIMIT_BASE + 2 * i)) begin
                v = lim_lo_q[i];
            end
            if (a == 8'(`HWM_REG_LIMIT_BASE + 2 * i + 1)) begin
                v = lim_hi_q[i];
            end
        end
        case (a)
            `HWM_REG_START: v = {7'h00, start_q};
            `HWM_REG_STAT1: v = {3'h0, stat1_q};
            `HWM_REG_STAT2: v = {6'h00, stat2_q};
            `HWM_REG_SFR: v = sfr_q;
            `HWM_REG_CFG: v = {6'h00, cfg_q};
            `HWM_REG_VOLT_EN: v = volt_en_q;
            `HWM_REG_TEMP_EN: v = temp_en_q;
            default: v = v;
        endcase
        return v;
    endfunction

    hwm_byte_t rd_data;
    // Function reads registers beyond its argument
    always_comb rd_data = read_mux(ptr_q);
    wire hwm_byte_t ara_byte = {own_addr, 1'b1};

    always_comb begin
        smb_state_d = smb_state_q;
        bit_cnt_d = bit_cnt_q;
        shift_d = shift_q;
        tx_d = tx_q;
        ptr_d = ptr_q;
        ara_pend_d = ara_pend_q;
        wr_strobe = 1'b0;
        rd_strobe = 1'b0;
        ara_ack = 1'b0;
        if (smb_stop) begin
            smb_state_d = SMB_IDLE;
        end else if (smb_start) begin
            smb_state_d = SMB_ADDR;
            bit_cnt_d = 4'h0;
        end else begin
            case (smb_state_q)
                SMB_ADDR, SMB_CMD, SMB_WDATA: begin
                    if (scl_rise && bit_cnt_q != 4'h8) begin
                        shift_d = {shift_q[6:0], sda_now};
                        bit_cnt_d = bit_cnt_q + 4'h1;
                    end else if (scl_fall && bit_cnt_q == 4'h8) begin
                        bit_cnt_d = 4'h0;
                        if (smb_state_q == SMB_CMD) begin
                            ptr_d = shift_q;
                            smb_state_d = SMB_ACK_CMD;
                        end else if (smb_state_q == SMB_WDATA) begin
                            wr_strobe = 1'b1;
                            smb_state_d = SMB_ACK_DATA;
                        end else if (addr_own && !addr_rd) begin
                            smb_state_d = SMB_ACK_ADDR_W;
                        end else if (addr_own && addr_rd) begin
                            tx_d = rd_data;
                            rd_strobe = 1'b1;
                            smb_state_d = SMB_ACK_ADDR_R;
                        end else if (addr_ara && addr_rd && ara_ok) begin
                            tx_d = ara_byte;
                            ara_pend_d = 1'b1;
                            smb_state_d = SMB_ACK_ADDR_R;
                        end else begin
                            smb_state_d = SMB_WAIT;
                        end
                    end
                end
                SMB_ACK_ADDR_W: begin
                    if (scl_fall) begin
                        smb_state_d = SMB_CMD;
                    end
                end
                SMB_ACK_CMD: begin
                    if (scl_fall) begin
                        smb_state_d = SMB_WDATA;
                    end
                end
                SMB_ACK_DATA: begin
                    if (scl_fall) begin
                        smb_state_d = SMB_WAIT;
                    end
                end
                SMB_ACK_ADDR_R: begin
                    if (scl_fall) begin
                        ara_ack = ara_pend_q;
                        ara_pend_d = 1'b0;
                        smb_state_d = SMB_TX;
                    end
                end
                SMB_TX: begin
                    if (scl_fall && bit_cnt_q == 4'h7) begin
                        smb_state_d = SMB_WAIT;
                    end else if (scl_fall) begin
                        tx_d = {tx_q[6:0], 1'b0};
                        bit_cnt_d = bit_cnt_q + 4'h1;
                    end
                end
                SMB_IDLE, SMB_WAIT: begin
                    smb_state_d = smb_state_q;
                end
                default: smb_state_d = SMB_IDLE;
            endcase
        end
    end

    wire ack_drive = (smb_state_q == SMB_ACK_ADDR_W) || (smb_state_q == SMB_ACK_CMD) ||
                     (smb_state_q == SMB_ACK_DATA) || (smb_state_q == SMB_ACK_ADDR_R);
    assign smb_sda_out = 1'b0;
    assign smb_sda_oe_out = ack_drive || ((smb_state_q == SMB_TX) && !tx_q[7]);
    assign fan_drive_pin_two_out = 1'b0;
    assign tach_input_pin_three_out = 1'b0;
    assign fan_drive_pin_two_oe_out = pin2_oe_q;
    assign tach_input_pin_three_oe_out = pin3_oe_q;

    always_ff @(posedge sys_clk_in) begin
        scl_sync_q <= {scl_sync_q[1:0], smb_scl_in};
        sda_sync_q <= {sda_sync_q[1:0], smb_sda_in};
        res_sync_q <= {res_sync_q[1:0], res_tgl_q};
    end

    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            smb_state_q <= SMB_IDLE;
            bit_cnt_q <= 4'h0;
            shift_q <= 8'h00;
            tx_q <= 8'h00;
            ptr_q <= 8'h00;
            ara_pend_q <= 1'b0;
        end else begin
            smb_state_q <= smb_state_d;
            bit_cnt_q <= bit_cnt_d;
            shift_q <= shift_d;
            tx_q <= tx_d;
            ptr_q <= ptr_d;
            ara_pend_q <= ara_pend_d;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (reg_rst) begin
            start_q <= 1'b0;
            sfr_q <= `HWM_SFR_RESET;
            cfg_q <= 2'h0;
            volt_en_q <= `HWM_VOLT_EN_RESET;
            temp_en_q <= `HWM_TEMP_EN_RESET;
        end else begin
            if (wr_start) begin
                start_q <= shift_q[0];
            end
            if (wr_sfr) begin
                sfr_q <= shift_q;
            end else if (ara_ack) begin
                sfr_q[`HWM_SFR_IRQ_EN] <= 1'b0;
            end
            if (wr_cfg) begin
                cfg_q <= shift_q[1:0];
            end
            if (wr_volt) begin
                volt_en_q <= shift_q;
            end
            if (wr_temp) begin
                temp_en_q <= shift_q;
            end
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (reg_rst) begin
            stat1_q <= 5'h00;
            stat2_q <= 2'h0;
            fault_now_q <= 2'h0;
            armed_q <= 1'b1;
            pin2_oe_q <= 1'b0;
            pin3_oe_q <= 1'b0;
        end else begin
            stat1_q <= stat1_d;
            stat2_q <= stat2_d;
            if (res_new && res_idx_q == 3'd0) begin
                fault_now_q[0] <= res_fault_q;
            end
            if (res_new && res_idx_q == `HWM_LAST_INPUT) begin
                fault_now_q[1] <= res_fault_q;
            end
            // Rearm on pass end so a fresh query follows a new pass
            armed_q <= pass_done | (armed_q & ~ara_ack);
            pin2_oe_q <= alert & cfg_q[`HWM_CFG_PIN2];
            pin3_oe_q <= alert & cfg_q[`HWM_CFG_PIN3];
        end
    end

    // Readings carry no reset value
    generate
        for (gi = 0; gi < `HWM_NUM_INPUTS; gi++) begin : g_regs
            always_ff @(posedge sys_clk_in) begin
                if (res_new && res_idx_q == 3'(gi)) begin
                    reading_q[gi] <= res_val_q;
                end
            end
            always_ff @(posedge sys_clk_in) begin
                if (reg_rst) begin
                    lim_lo_q[gi] <= `HWM_LIMIT_LO_RESET;
                    lim_hi_q[gi] <= `HWM_LIMIT_HI_RESET;
                end else if (wr_strobe && ptr_q == 8'(`HWM_REG_LIMIT_BASE + 2 * gi)) begin
                    lim_lo_q[gi] <= shift_q;
                end else if (wr_strobe && ptr_q == 8'(`HWM_REG_LIMIT_BASE + 2 * gi + 1)) begin
                    lim_hi_q[gi] <= shift_q;
                end
            end
        end
    endgenerate

    // Conversion clock domain
    logic [1:0] crst_sync_q;
    logic [4:0] cfg_sync1_q;
    logic [4:0] cfg_sync2_q;
    wire conv_rst = crst_sync_q[1];
    wire cfg_start = cfg_sync2_q[0];
    wire cfg_mode = cfg_sync2_q[1];

    hwm_seq_state_t seq_q;
    logic [6:0] clk_cnt_q;
    logic [7:0] samp_cnt_q;
    logic [2:0] idx_q;
    logic [14:0] acc_q;
    logic fault_acc_q;
    logic [15:0] idle_cnt_q;
    logic [2:0] avg_q;

    function automatic logic [2:0] avg_shift(input logic [2:0] avg, input logic [2:0] idx);
        logic remote;
        remote = (idx == 3'd0) || (idx == `HWM_LAST_INPUT);
        if (avg[2]) begin
            return 3'd5;
        end else if (avg[1]) begin
            return 3'd4;
        end else if (avg[0]) begin
            return remote ? 3'd4 : 3'd0;
        end
        return remote ? 3'd7 : 3'd3;
    endfunction

    wire is_temp = (idx_q != 3'd2) && (idx_q != 3'd3);
    wire [6:0] conv_last = (is_temp ? `HWM_TEMP_CLKS : `HWM_VOLT_CLKS) - 7'd1;
    wire [2:0] shift_n = avg_shift(avg_q, idx_q);
    wire [7:0] samp_last = 8'((9'd1 << shift_n) - 9'd1);
    wire conv_end = (seq_q == SEQ_CONV) && (clk_cnt_q == conv_last);
    wire last_samp = conv_end && (samp_cnt_q == samp_last);
    wire [14:0] sum = acc_q + {7'h00, adc_data_in};
    wire [14:0] avg_val = sum >> shift_n;
    wire [15:0] idle_last = 16'(IDLE_CLKS - 1);

    always_ff @(posedge conv_clk_in) begin
        crst_sync_q <= {crst_sync_q[0], reset_in};
        cfg_sync1_q <= {sfr_q[7:5], sfr_q[`HWM_SFR_MODE], start_q};
        cfg_sync2_q <= cfg_sync1_q;
    end

    assign adc_sel_out = idx_q;
    assign adc_busy_out = (seq_q == SEQ_CONV);

    always_ff @(posedge conv_clk_in) begin
        if (conv_rst) begin
            res_tgl_q <= 1'b0;
            res_val_q <= 8'h00;
            res_idx_q <= 3'd0;
            res_fault_q <= 1'b0;
        end else if (last_samp) begin
            res_val_q <= (fault_acc_q | adc_fault_in) ? `HWM_FAULT_READING : avg_val[7:0];
            res_idx_q <= idx_q;
            res_fault_q <= fault_acc_q | adc_fault_in;
            res_tgl_q <= ~res_tgl_q;
        end
    end

    always_ff @(posedge conv_clk_in) begin
        if (conv_rst || !cfg_start) begin
            seq_q <= SEQ_IDLE;
            clk_cnt_q <= 7'd0;
            samp_cnt_q <= 8'd0;
            idx_q <= 3'd0;
            acc_q <= 15'd0;
            fault_acc_q <= 1'b0;
            idle_cnt_q <= 16'd0;
            avg_q <= cfg_sync2_q[4:2];
        end else begin
            case (seq_q)
                SEQ_IDLE: begin
                    seq_q <= SEQ_CONV;
                    avg_q <= cfg_sync2_q[4:2];
                end
                SEQ_CONV: begin
                    clk_cnt_q <= conv_end ? 7'd0 : clk_cnt_q + 7'd1;
                    if (last_samp) begin
                        acc_q <= 15'd0;
                        fault_acc_q <= 1'b0;
                        samp_cnt_q <= 8'd0;
                        if (idx_q == `HWM_LAST_INPUT) begin
                            idx_q <= 3'd0;
                            avg_q <= cfg_sync2_q[4:2];
                            seq_q <= cfg_mode ? SEQ_PAUSE : SEQ_CONV;
                        end else begin
                            idx_q <= idx_q + 3'd1;
                        end
                    end else if (conv_end) begin
                        acc_q <= sum;
                        fault_acc_q <= fault_acc_q | adc_fault_in;
                        samp_cnt_q <= samp_cnt_q + 8'd1;
                    end
                end
                SEQ_PAUSE: begin
                    idle_cnt_q <= idle_cnt_q + 16'd1;
                    if (idle_cnt_q == idle_last) begin
                        idle_cnt_q <= 16'd0;
                        seq_q <= SEQ_CONV;
                    end
                end
                default: seq_q <= SEQ_IDLE;
            endcase
        end
    end
endmodule

/* File: rtl/hwm_pkg.sv */
package hwm_pkg;
    typedef logic [7:0] hwm_byte_t;
    typedef enum logic [3:0] {
        SMB_IDLE = 4'h0,
        SMB_ADDR = 4'h1,
        SMB_ACK_ADDR_W = 4'h2,
        SMB_CMD = 4'h3,
        SMB_ACK_CMD = 4'h4,
        SMB_WDATA = 4'h5,
        SMB_ACK_DATA = 4'h6,
        SMB_ACK_ADDR_R = 4'h7,
        SMB_TX = 4'h8,
        SMB_WAIT = 4'h9
    } hwm_smb_state_t;
    typedef enum logic [1:0] {
        SEQ_IDLE = 2'h0,
        SEQ_CONV = 2'h1,
        SEQ_PAUSE = 2'h2
    } hwm_seq_state_t;
endpackage
